//--- design/csrb_params.svh
// Register offsets, field positions, reset values and frame counts of the core register bank
`ifndef CSRB_PARAMS_SVH
`define CSRB_PARAMS_SVH

`define CSRB_OFF_INDIRECT   6'h00
`define CSRB_OFF_STATUS     6'h03
`define CSRB_OFF_POINTER    6'h04
`define CSRB_OFF_PORT5      6'h05
`define CSRB_OFF_PORT6      6'h06
`define CSRB_OFF_PORT7      6'h07
`define CSRB_OFF_PORT8      6'h08
`define CSRB_OFF_DISPLAY    6'h09

`define CSRB_ST_PAGE_HI     6
`define CSRB_ST_PAGE_LO     5
`define CSRB_ST_TIMEOUT     4
`define CSRB_ST_PWRDN       3
`define CSRB_ST_ZERO        2
`define CSRB_ST_HALF        1
`define CSRB_ST_CARRY       0

`define CSRB_DC_BIAS        7
`define CSRB_DC_DUTY_HI     6
`define CSRB_DC_DUTY_LO     5
`define CSRB_DC_ENABLE      4
`define CSRB_DC_SHAPE       2

`define CSRB_MASK_STATUS    8'h67
`define CSRB_MASK_PORT5     8'hf1
`define CSRB_MASK_DISPLAY   8'hf7

`define CSRB_RST_STATUS     8'h18
`define CSRB_RST_POINTER    8'h00
`define CSRB_RST_PORT       8'h00
`define CSRB_RST_DISPLAY    8'h00

`define CSRB_FR_HALF_0      9'd256
`define CSRB_FR_HALF_1      9'd280
`define CSRB_FR_HALF_2      9'd304
`define CSRB_FR_HALF_3      9'd232
`define CSRB_FR_THIRD_0     9'd172
`define CSRB_FR_THIRD_1     9'd188
`define CSRB_FR_THIRD_2     9'd204
`define CSRB_FR_THIRD_3     9'd156
`define CSRB_FR_QUART_0     9'd128
`define CSRB_FR_QUART_1     9'd140
`define CSRB_FR_QUART_2     9'd152
`define CSRB_FR_QUART_3     9'd116

`endif

//--- design/csrb_pkg.sv
// Types shared by the core register bank
package csrb_pkg;

  typedef logic [7:0] csrb_byte_t;

  typedef enum logic [1:0]
  {
    CSRB_DUTY_HALF    = 2'h0,
    CSRB_DUTY_THIRD   = 2'h1,
    CSRB_DUTY_QUARTER = 2'h3
  } csrb_duty_e;

endpackage

//--- design/csrb_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps

module csrb_sync
#(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b0
)
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_r <= {W{RST_VAL}};
      q_o    <= {W{RST_VAL}};
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

//--- design/csrb_reg_bank.sv
// Special register bank of the 8-bit core: status, pointer, port data, display control
//
// Summary of operation
// - Page field codes 0..3 pick four 1K-word program pages, 000H to FFFH.
// - Jump, call or counter write copies page field into counter bits 11:10.
// - Returns keep the page field and restore the full stacked address.
// - Page field written by page instruction or by ordinary status write.
// - Timeout flag set by sleep, watchdog clear, power-up; cleared by timeout.
// - Power-down flag set at power-on or watchdog clear; cleared by sleep.
// - Flags read 0/0 watchdog wake, 0/1 timeout awake, 1/0 pin wake.
// - Status bits 2..0 hold zero, half carry and carry from the ALU.
// - Pointer bits 7:6 choose one of four data banks; bank instruction sets them.
// - Pointer bits 5:0 give the indirect address 00 to 3F.
// - Without indirect use the pointer is a plain 8-bit storage byte.
// - Port 5 bits 7:4 latch four pins; direction per matching direction bit.
// - Port 5 bit 0 selects control register page 0 or 1.
// - Ports 6, 7, 8 hold eight pin latches each with own direction.
// - Display bit 7 picks one-half bias at 0, one-third bias at 1.
// - Display bits 6:5 pick duty 1/2 at 00, 1/3 at 01, 1/4 at 1X.
// - Display bit 4 low disables drive, commons and segments held at ground.
// - Display bit 2 picks waveform A at 0 and waveform B at 1.
// - Display bits 1:0 set frame length N times duty count of sub-clock cycles.
// - Access to location zero goes to the location the pointer names.
`timescale 1ns/100ps
`include "csrb_params.svh"

module csrb_reg_bank
  import csrb_pkg::*;
#(
  parameter int PC_LOW_W = 10
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ext_rst_n_i,
  // Register access from the core
  input  wire logic [5:0]  acc_addr_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             rhit_o,
  output logic      [5:0]  eff_addr_o,
  // Instruction events
  input  wire logic        alu_flag_we_i,
  input  wire logic        alu_zero_i,
  input  wire logic        alu_half_i,
  input  wire logic        alu_carry_i,
  input  wire logic        page_instr_i,
  input  wire logic [1:0]  page_val_i,
  input  wire logic        bank_instr_i,
  input  wire logic [1:0]  bank_val_i,
  input  wire logic        sleep_instr_i,
  input  wire logic        watchdog_clear_instruction_i,
  input  wire logic        watchdog_timeout_i,
  output logic             sleeping_o,
  // Program counter
  input  wire logic        pc_load_i,
  input  wire logic [9:0]  pc_low_i,
  input  wire logic        pc_ret_i,
  input  wire logic [11:0] ret_addr_i,
  output logic      [11:0] pc_o,
  // Port pins and directions, direction bit high means input
  input  wire logic [3:0]  port5_pin_i,
  input  wire logic [7:0]  port6_pin_i,
  input  wire logic [7:0]  port7_pin_i,
  input  wire logic [7:0]  port8_pin_i,
  input  wire logic [3:0]  port5_direction_register_i,
  input  wire logic [7:0]  port6_direction_register_i,
  input  wire logic [7:0]  port7_direction_register_i,
  input  wire logic [7:0]  port8_direction_register_i,
  output logic      [3:0]  port5_latch_o,
  output logic      [7:0]  port6_latch_o,
  output logic      [7:0]  port7_latch_o,
  output logic      [7:0]  port8_latch_o,
  output logic             control_page_select_o,
  // Core state
  output logic      [1:0]  data_bank_o,
  output logic      [5:0]  indirect_pointer_o,
  output logic      [7:0]  core_status_o,
  // Display configuration
  output logic             bias_select_o,
  output csrb_duty_e       duty_o,
  output logic             display_drive_enable_o,
  output logic             waveform_shape_select_o,
  output logic      [9:0]  frame_len_o
);

  // ==========================================================
  // Elaboration check
  if (PC_LOW_W != 10)
  begin : g_bad_pc
    $error("csrb_reg_bank: PC_LOW_W must be 10");
  end

  // ==========================================================
  // Pin synchronisers
  logic        ext_rst_n_s;
  logic [27:0] pin_s;

  csrb_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync
    (.clk_i(clk_i), .arst_n_i(arst_n_i), .d_i(ext_rst_n_i), .q_o(ext_rst_n_s));

  csrb_sync #(.W(28), .RST_VAL(1'b0)) u_pin_sync
    (.clk_i(clk_i), .arst_n_i(arst_n_i),
     .d_i({port8_pin_i, port7_pin_i, port6_pin_i, port5_pin_i}), .q_o(pin_s));

  // ==========================================================
  // Registers
  csrb_byte_t status_r;
  csrb_byte_t pointer_r;
  csrb_byte_t port_r [4];
  csrb_byte_t display_r;
  logic       sleep_r, rst_seen_r;

  // ==========================================================
  // Address decode
  wire        soft_rst = !ext_rst_n_s;
  wire  [5:0] eff_addr = (acc_addr_i == `CSRB_OFF_INDIRECT) ? pointer_r[5:0]
                                                            : acc_addr_i;
  wire        wr_st    = wr_en_i && (eff_addr == `CSRB_OFF_STATUS);
  wire        wr_ptr   = wr_en_i && (eff_addr == `CSRB_OFF_POINTER);
  wire        wr_disp  = wr_en_i && (eff_addr == `CSRB_OFF_DISPLAY);
  wire  [7:0] wmask_st = wdata_i & `CSRB_MASK_STATUS;

  // ==========================================================
  // Status register
  logic [7:0] status_nxt;
  wire        wdt_wake = watchdog_timeout_i && sleep_r;

  always_comb
  begin
    status_nxt = status_r;
    if (wr_st)
      status_nxt = {1'b0, wmask_st[6:5], status_r[4:3], wmask_st[2:0]};
    if (alu_flag_we_i)
      status_nxt[2:0] = {alu_zero_i, alu_half_i, alu_carry_i};
    if (page_instr_i)
      status_nxt[6:5] = page_val_i;
    if (sleep_instr_i)
      status_nxt[4:3] = 2'b10;
    if (watchdog_clear_instruction_i)
      status_nxt[4:3] = 2'b11;
    if (watchdog_timeout_i)
      status_nxt[4:3] = {1'b0, !sleep_r};
  end

  // Pin reset wins over all events; only its first cycle samples sleep, later ones hold it
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      status_r <= `CSRB_RST_STATUS;
    else if (soft_rst)
      status_r <= {3'b000, 1'b1, rst_seen_r ? status_r[3] : !sleep_r, 3'b000};
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sleep_r <= 1'b0;
    else if (soft_rst || wdt_wake)
      sleep_r <= 1'b0;
    else if (sleep_instr_i)
      sleep_r <= 1'b1;
  end

  // ==========================================================
  // Pointer register
  wire [7:0] pointer_nxt = bank_instr_i ? {bank_val_i, pointer_r[5:0]}
                         : wr_ptr       ? wdata_i
                         : pointer_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pointer_r <= `CSRB_RST_POINTER;
    else if (soft_rst)
      pointer_r <= `CSRB_RST_POINTER;
    else
      pointer_r <= pointer_nxt;
  end

  // ==========================================================
  // Port latches, one per port, read back pin when direction is input
  wire [31:0] dir_all = {port8_direction_register_i, port7_direction_register_i,
                         port6_direction_register_i, port5_direction_register_i, 4'h0};
  wire [31:0] pin_all = {pin_s, 4'h0};
  wire  [7:0] port_mask [4];
  wire  [7:0] port_rd   [4];

  assign port_mask[0] = `CSRB_MASK_PORT5;
  assign port_mask[1] = 8'hff;
  assign port_mask[2] = 8'hff;
  assign port_mask[3] = 8'hff;

  for (genvar p = 0; p < 4; p++)
  begin : g_port
    wire [7:0] dir = dir_all[8*p +: 8];
    wire       wr  = wr_en_i && (eff_addr == `CSRB_OFF_PORT5 + 6'(p));

    assign port_rd[p] = ((pin_all[8*p +: 8] & dir) | (port_r[p] & ~dir))
                        & port_mask[p];

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
        port_r[p] <= `CSRB_RST_PORT;
      else if (soft_rst)
        port_r[p] <= `CSRB_RST_PORT;
      else if (wr)
        port_r[p] <= wdata_i & port_mask[p];
    end
  end

  // ==========================================================
  // Display control and frame length
  wire       duty_q  = display_r[`CSRB_DC_DUTY_HI];
  wire       duty_t  = !duty_q && display_r[`CSRB_DC_DUTY_LO];
  wire [1:0] fr_code = display_r[1:0];
  logic [8:0] frame_n;

  // Sub-clock cycles per frame step; multiplied by duty count below
  always_comb
  begin
    case ({duty_q, duty_t, fr_code})
      4'b0000: frame_n = `CSRB_FR_HALF_0;
      4'b0001: frame_n = `CSRB_FR_HALF_1;
      4'b0010: frame_n = `CSRB_FR_HALF_2;
      4'b0011: frame_n = `CSRB_FR_HALF_3;
      4'b0100: frame_n = `CSRB_FR_THIRD_0;
      4'b0101: frame_n = `CSRB_FR_THIRD_1;
      4'b0110: frame_n = `CSRB_FR_THIRD_2;
      4'b0111: frame_n = `CSRB_FR_THIRD_3;
      4'b1000: frame_n = `CSRB_FR_QUART_0;
      4'b1001: frame_n = `CSRB_FR_QUART_1;
      4'b1010: frame_n = `CSRB_FR_QUART_2;
      4'b1011: frame_n = `CSRB_FR_QUART_3;
      default: frame_n = `CSRB_FR_HALF_0;
    endcase
  end

  wire [10:0] frame_x3 = {1'b0, frame_n, 1'b0} + {2'b00, frame_n};
  wire [9:0]  frame_nxt = duty_q ? {frame_n[7:0], 2'b00}
                        : duty_t ? frame_x3[9:0]
                        : {frame_n, 1'b0};
  wire csrb_duty_e duty_nxt = duty_q ? CSRB_DUTY_QUARTER
                            : duty_t ? CSRB_DUTY_THIRD
                            : CSRB_DUTY_HALF;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      display_r <= `CSRB_RST_DISPLAY;
    else if (soft_rst || wr_disp)
      display_r <= soft_rst ? `CSRB_RST_DISPLAY : wdata_i & `CSRB_MASK_DISPLAY;
  end

  // ==========================================================
  // Program counter page handling
  wire [11:0] pc_nxt = pc_ret_i  ? ret_addr_i
                     : pc_load_i ? {status_r[6:5], pc_low_i}
                     : pc_o;

  // ==========================================================
  // Read path
  logic [7:0] rd_nxt;
  logic       hit_nxt;

  always_comb
  begin
    hit_nxt = 1'b1;
    rd_nxt  = 8'h00;
    case (eff_addr)
      `CSRB_OFF_STATUS:  rd_nxt = status_r;
      `CSRB_OFF_POINTER: rd_nxt = pointer_r;
      `CSRB_OFF_PORT5:   rd_nxt = port_rd[0];
      `CSRB_OFF_PORT6:   rd_nxt = port_rd[1];
      `CSRB_OFF_PORT7:   rd_nxt = port_rd[2];
      `CSRB_OFF_PORT8:   rd_nxt = port_rd[3];
      `CSRB_OFF_DISPLAY: rd_nxt = display_r;
      default:           hit_nxt = 1'b0;
    endcase
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o     <= 8'h00;
      rhit_o      <= 1'b0;
      eff_addr_o  <= 6'h00;
      pc_o        <= 12'h000;
      frame_len_o <= 10'h000;
      duty_o      <= CSRB_DUTY_HALF;
      rst_seen_r  <= 1'b0;
    end
    else
    begin
      rdata_o     <= rd_en_i ? rd_nxt : 8'h00;
      rhit_o      <= rd_en_i && hit_nxt;
      eff_addr_o  <= eff_addr;
      pc_o        <= pc_nxt;
      frame_len_o <= frame_nxt;
      duty_o      <= duty_nxt;
      rst_seen_r  <= soft_rst;
    end
  end

  // Direct register views
  assign core_status_o           = status_r;
  assign sleeping_o              = sleep_r;
  assign data_bank_o             = pointer_r[7:6];
  assign indirect_pointer_o      = pointer_r[5:0];
  assign port5_latch_o           = port_r[0][7:4];
  assign port6_latch_o           = port_r[1];
  assign port7_latch_o           = port_r[2];
  assign port8_latch_o           = port_r[3];
  assign control_page_select_o   = port_r[0][0];
  assign bias_select_o           = display_r[`CSRB_DC_BIAS];
  assign display_drive_enable_o  = display_r[`CSRB_DC_ENABLE];
  assign waveform_shape_select_o = display_r[`CSRB_DC_SHAPE];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  page_to_pc_a: assert property (pc_load_i && !pc_ret_i
    |=> pc_o[11:10] == $past(status_r[6:5])) else $error("page not copied into counter");
  ret_keeps_a: assert property (pc_ret_i && !soft_rst && !page_instr_i && !wr_st
    |=> pc_o == $past(ret_addr_i) && status_r[6:5] == $past(status_r[6:5]))
    else $error("return altered page or address");
  page_instr_a: assert property (page_instr_i && !soft_rst
    |=> status_r[6:5] == $past(page_val_i)) else $error("page instruction lost");
  sleep_flags_a: assert property (sleep_instr_i && !soft_rst
    && !watchdog_clear_instruction_i && !watchdog_timeout_i |=> status_r[4:3] == 2'b10)
    else $error("sleep flags wrong");
  wdt_clear_a: assert property (watchdog_clear_instruction_i && !watchdog_timeout_i
    && !soft_rst |=> status_r[4:3] == 2'b11) else $error("watchdog clear flags wrong");
  wdt_wake_a: assert property (sleep_r && watchdog_timeout_i && !soft_rst
    |=> status_r[4:3] == 2'b00 && !sleep_r) else $error("watchdog wake flags wrong");
  pin_wake_a: assert property (sleep_r && soft_rst |=> status_r[4:3] == 2'b10)
    else $error("pin wake flags wrong");
  alu_flags_a: assert property (alu_flag_we_i && !soft_rst
    |=> status_r[2:0] == $past({alu_zero_i, alu_half_i, alu_carry_i}))
    else $error("alu flags not stored");
  indirect_rd_a: assert property (rd_en_i && acc_addr_i == 6'h00
    && pointer_r[5:0] == 6'h04 |=> rdata_o == $past(pointer_r) && rhit_o)
    else $error("indirect read wrong");
  unused_zero_a: assert property (status_r[7] == 1'b0 && display_r[3] == 1'b0
    && port_r[0][3:1] == 3'b000) else $error("unused bit set");
  frame_len_a: assert property (##1 duty_q && fr_code == 2'b11
    |=> frame_len_o == 10'd464) else $error("frame length wrong");

  sleep_wake_c: cover property (sleep_instr_i ##1 sleep_r [*3] ##1 watchdog_timeout_i);
  pin_wake_c:   cover property (sleep_r ##1 soft_rst);
  indirect_c:   cover property (wr_en_i && acc_addr_i == 6'h00);
  jump_page_c:  cover property (page_instr_i ##1 pc_load_i);

endmodule

//--- bench/csrb_core_model.sv
// Core-side model: issues register reads and writes on the access port
`timescale 1ns/100ps

module csrb_core_model
(
  // Clock
  input  wire logic       clk_i,
  // Access port
  output logic      [5:0] acc_addr_o,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rhit_i
);
  initial
  begin
    acc_addr_o = 6'h3f;
    wr_en_o    = 1'b0;
    rd_en_o    = 1'b0;
    wdata_o    = 8'h00;
  end

  // Random idle gap, so the block sees prompt and slow cores alike
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    repeat ($urandom_range(1, 0)) @(negedge clk_i);
    @(negedge clk_i);
    acc_addr_o = a;
    wdata_o    = d;
    wr_en_o    = 1'b1;
    @(negedge clk_i);
    wr_en_o    = 1'b0;
    acc_addr_o = ~a;
    wdata_o    = ~d;
  endtask

  // Read data stands one cycle only, so it is taken at the next falling edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic h);
    repeat ($urandom_range(1, 0)) @(negedge clk_i);
    @(negedge clk_i);
    acc_addr_o = a;
    rd_en_o    = 1'b1;
    @(negedge clk_i);
    d          = rdata_i;
    h          = rhit_i;
    rd_en_o    = 1'b0;
    acc_addr_o = ~a;
  endtask
endmodule

//--- bench/tb_core_special_register_bank.sv
// Testbench: core register bank against a behavioural model
`timescale 1ns/100ps
`include "csrb_params.svh"

module tb_core_special_register_bank
  import csrb_pkg::*;
;
  // ==========================================
  // Signals
  logic        clk, arst_n, ext_rst_n, zf, hf, cf, sleeping, rhit, rd_en, wr_en, cps;
  logic        bias, en, shape;
  logic [1:0]  pval, bval, bank;
  logic [3:0]  p5pin, dir5, p5l;
  logic [5:0]  addr, eff, ptr;
  logic [7:0]  ev, wdata, rdata, status, p6pin, p7pin, p8pin, dir6, dir7, dir8, p6l, p7l, p8l;
  logic [9:0]  pc_low, frame;
  logic [11:0] ret_addr, pc, pcx;
  csrb_duty_e  duty;
  logic [7:0]  mdl [0:63];
  logic        slp;
  int          err_total, checked, ds, nt [3][4];

  csrb_core_model u_core (.clk_i(clk), .acc_addr_o(addr), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .wdata_o(wdata), .rdata_i(rdata), .rhit_i(rhit));

  csrb_reg_bank u_dut (.clk_i(clk), .arst_n_i(arst_n), .ext_rst_n_i(ext_rst_n),
    .acc_addr_i(addr), .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata),
    .rhit_o(rhit), .eff_addr_o(eff), .alu_flag_we_i(ev[5]), .alu_zero_i(zf),
    .alu_half_i(hf), .alu_carry_i(cf), .page_instr_i(ev[3]), .page_val_i(pval),
    .bank_instr_i(ev[4]), .bank_val_i(bval), .sleep_instr_i(ev[0]),
    .watchdog_clear_instruction_i(ev[1]), .watchdog_timeout_i(ev[2]),
    .sleeping_o(sleeping), .pc_load_i(ev[6]), .pc_low_i(pc_low), .pc_ret_i(ev[7]),
    .ret_addr_i(ret_addr), .pc_o(pc), .port5_pin_i(p5pin), .port6_pin_i(p6pin),
    .port7_pin_i(p7pin), .port8_pin_i(p8pin), .port5_direction_register_i(dir5),
    .port6_direction_register_i(dir6), .port7_direction_register_i(dir7),
    .port8_direction_register_i(dir8), .port5_latch_o(p5l), .port6_latch_o(p6l),
    .port7_latch_o(p7l), .port8_latch_o(p8l), .control_page_select_o(cps),
    .data_bank_o(bank), .indirect_pointer_o(ptr), .core_status_o(status),
    .bias_select_o(bias), .duty_o(duty), .display_drive_enable_o(en),
    .waveform_shape_select_o(shape), .frame_len_o(frame));

  // ==========================================
  // Checking and model tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr_mdl(input logic [5:0] a, input logic [7:0] d);
    logic [5:0] e;
    logic [7:0] m;
    e = (a == 6'h00) ? mdl[4][5:0] : a;
    m = (e == 6'h03) ? `CSRB_MASK_STATUS : (e == 6'h05) ? `CSRB_MASK_PORT5 :
        (e == 6'h09) ? `CSRB_MASK_DISPLAY : 8'hff;
    if (e >= 6'h03 && e <= 6'h09)
      mdl[e] = (mdl[e] & ~m) | (d & m);
    u_core.wr(a, d);
  endtask

  task automatic rd_chk(input logic [5:0] a);
    logic [7:0] d;
    logic       h;
    logic [5:0] e;
    e = (a == 6'h00) ? mdl[4][5:0] : a;
    u_core.rd(a, d, h);
    chk(d, (e >= 6'h03 && e <= 6'h09) ? mdl[e] : 8'h00);
    chk(h, e >= 6'h03 && e <= 6'h09);
    chk(eff, e);
  endtask

  // One instruction event pulse, then the model follows it
  task automatic strobe(input int k);
    @(negedge clk);
    ev = 8'h01 << k;
    @(negedge clk);
    ev = 8'h00;
    case (k)
      0: {mdl[3][4:3], slp} = 3'b101;
      1: mdl[3][4:3] = 2'b11;
      2: {mdl[3][4:3], slp} = {1'b0, ~slp, 1'b0};
      3: mdl[3][6:5] = pval;
      4: mdl[4][7:6] = bval;
      5: mdl[3][2:0] = {zf, hf, cf};
      6: pcx = {mdl[3][6:5], pc_low};
      default: pcx = ret_addr;
    endcase
    chk(status, mdl[3]);
    chk({pc, 3'h0, sleeping}, {pcx, 3'h0, slp});
    chk({bank, ptr}, mdl[4]);
  endtask

  // Pin reset wakes from sleep: timeout set, power-down shows the sleep
  task automatic pin_reset();
    @(negedge clk);
    ext_rst_n = 1'b0;
    repeat (4) @(negedge clk);
    ext_rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(status & 8'h18, {3'h0, 1'b1, ~slp, 3'h0});
    for (int i = 4; i <= 9; i++)
      mdl[i] = 8'h00;
    mdl[3] = {3'h0, 1'b1, ~slp, 3'h0};
    slp = 1'b0;
    wr_mdl(6'h03, 8'h00);
  endtask

  // ==========================================
  // Clock, stimulus and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #2_000_000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0] d;
    logic [5:0] a;
    logic       h;
    nt = '{'{256, 280, 304, 232}, '{172, 188, 204, 156}, '{128, 140, 152, 116}};
    {arst_n, ext_rst_n, ev, zf, hf, cf, pval, bval, pc_low, ret_addr} = '0;
    ext_rst_n = 1'b1;
    {dir5, dir6, dir7, dir8} = '0;
    void'($urandom(32'h05feb9e2));
    {p5pin, p6pin, p7pin, p8pin} = 28'($urandom);
    for (int i = 0; i < 64; i++)
      mdl[i] = 8'h00;
    mdl[3] = `CSRB_RST_STATUS;
    slp = 1'b0;
    pcx = 12'h000;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 3; i <= 11; i++)
      rd_chk(6'(i));
    // Every duty and frame code, with random bias, enable, shape and unused bit
    for (int c = 0; c < 16; c++)
    begin
      d = {8'($urandom) & 8'h9c} | {1'b0, 2'(c >> 2), 3'h0, 2'(c)};
      wr_mdl(6'h09, d);
      @(negedge clk);
      ds = d[6] ? 2 : d[5] ? 1 : 0;
      chk(duty, {d[6], d[6] | d[5]});
      chk(frame, nt[ds][d[1:0]] * (ds + 2));
      chk({bias, en, shape}, {d[7], d[4], d[2]});
      rd_chk(6'h09);
    end
    // Indirect access onto the pointer itself, then an indirect write to the display
    wr_mdl(6'h04, 8'h84);
    rd_chk(6'h00);
    wr_mdl(6'h04, 8'h49);
    wr_mdl(6'h00, 8'h5a);
    rd_chk(6'h00);
    rd_chk(6'h09);
    // Input-direction port bits return the pins
    dir6 = 8'hff;
    repeat (3) @(negedge clk);
    u_core.rd(6'h06, d, h);
    chk(d, p6pin);
    dir6 = 8'h00;
    strobe(0);
    pin_reset();
    pin_reset();
    // Random mix of instruction events and bus traffic, indirect included
    for (int n = 0; n < 400; n++)
    begin
      {zf, hf, cf, pval, bval, pc_low, ret_addr} = 29'($urandom);
      a = 6'($urandom_range(11, 0));
      case ($urandom_range(9, 0))
        8: wr_mdl(a, 8'($urandom));
        9: rd_chk(a);
        default: strobe($urandom_range(7, 0));
      endcase
      chk({p6l, p7l}, {mdl[6], mdl[7]});
      chk({p5l, cps, p8l}, {mdl[5][7:4], mdl[5][0], mdl[8]});
    end
    tally_and_finish();
  end
endmodule
